// [core/icfg_pkg.sv]
// shared constants for the i2c configuration slave and its controller
package icfg_pkg;
    // timing base
    localparam int CLK_NS = 10;
    // dither modulation periods
    localparam int DITHER_SHORT_NS = 120000;
    localparam int DITHER_LONG_NS = 150000;
    // bus free time after stop, rounded up
    localparam int BUS_FREE_NS = 4700;
    localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
    // fast mode bit period, quarter rounded up so the rate stays at or below 400 khz
    localparam int SCL_NS = 2500;
    localparam int SCL_QTR_CYC = (SCL_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
    // strap band 0 address, bands count upward
    localparam logic [6:0] ADDR_BASE = 7'h21;
    // configuration store
    localparam int NREG = 4;
    localparam int OTP_PAGES = 3;
    localparam logic [NREG*8-1:0] OTP_DEF = 32'h0000_0000;
    // dither field in configuration byte 0
    localparam int DITHER_REG = 0;
    localparam int DITHER_RANGE_BIT = 0;
    localparam int DITHER_PERIOD_BIT = 1;
    // controller register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SLAVE = 8'h04;
    localparam logic [7:0] OFS_REGA = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    // controller fields
    localparam int CTRL_GO_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
endpackage

// [core/icfg_if.sv]
// two wire link between controller and configuration slave
`timescale 1ns/1ps
interface icfg_if;
    // drivers, enable high means the party drives its output
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    // resolved wire levels, pulled up when nobody drives low
    logic scl;
    logic sda;
    assign scl = ~(scl_m_oe & ~scl_m_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
    modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport host (input scl, input sda, output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe);
endinterface

// [core/icfg_dev.sv]
// device end: i2c configuration slave with three page otp loader
//
// Behaviour
// - dither range and period set over bus
// - three otp pages, first holds defaults
// - on enable load defaults from page one
// - newest programmed page then overrides registers
// - slave works at fast and high speed rates
// - data changes only while clock low
// - start and stop detected while clock high
// - master waits bus free time after stop
// - repeated start handled exactly like start
// - eight bits msb first plus acknowledge
// - receiver holds data low during acknowledge
// - master generates every clock pulse
// - first byte: seven bit address, direction
// - master ends with stop or repeated start
// - write: address, register byte, data byte
// - matching slave acknowledges every received byte
// - commit data on falling edge after lsb
// - strap selects one of eight addresses
// - bus ignored until enabled and loaded
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module icfg_dev #(
    parameter int NREG = icfg_pkg::NREG,
    parameter logic [NREG*8-1:0] DEF_PAGE = icfg_pkg::OTP_DEF,
    parameter int DITHER_SHORT_CYC = icfg_pkg::DITHER_SHORT_NS / icfg_pkg::CLK_NS,
    parameter int DITHER_LONG_CYC = icfg_pkg::DITHER_LONG_NS / icfg_pkg::CLK_NS
) (
    // clock, reset, clock enable
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              ce,
    // two wire link
    icfg_if.dev                    bus,
    // device pins
    input  wire logic              en_pin,
    input  wire logic [2:0]        addr_sel,
    // otp pages two and three, newest page indicator
    input  wire logic [NREG*8-1:0] otp_page1,
    input  wire logic [NREG*8-1:0] otp_page2,
    input  wire logic [1:0]        otp_prog,
    // configuration outputs
    output logic                   ready_q,
    output logic [NREG*8-1:0]      cfg_q,
    output logic                   dither_wide_q,
    output logic                   dither_long_q,
    output logic                   dither_up_q
);
    localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;
    // refuse sizes the logic cannot serve
    if (NREG < 1 || NREG > 256 || DITHER_SHORT_CYC < 2 || DITHER_LONG_CYC < 2) begin : g_chk
        $error("register count or dither periods out of range");
    end
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_ADDR = 8'h02,
        S_ACKA = 8'h04,
        S_REG  = 8'h08,
        S_ACKR = 8'h10,
        S_DATA = 8'h20,
        S_ACKD = 8'h40,
        S_SKIP = 8'h80
    } icfg_sst_t;
    typedef enum logic [3:0] {
        L_OFF = 4'h1,
        L_DEF = 4'h2,
        L_NEW = 4'h4,
        L_RDY = 4'h8
    } icfg_lst_t;
    icfg_sst_t         st_q;
    icfg_lst_t         ld_q;
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic [1:0]        en_s;
    logic [2:0]        asel_s0;
    logic [2:0]        asel_s1;
    logic [6:0]        dev_addr_q;
    logic [IW-1:0]     idx_q;
    logic [7:0]        shift_q;
    logic [3:0]        cnt_q;
    logic [7:0]        ptr_q;
    logic              sda_oe_q;
    logic [31:0]       dcnt_q;
    logic [31:0]       dhalf;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_ev;
    logic              stop_ev;
    logic              commit;
    logic [7:0]        otp_mem [icfg_pkg::OTP_PAGES][NREG];
    // open drain: only ever drives low
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = sda_oe_q;
    // two flip-flop synchronisers, third stage for edges
    // oversampling serves both rates
    always_ff @(posedge mclk) begin
        if (reset) begin
            scl_s <= 3'b111;
            sda_s <= 3'b111;
            en_s <= 2'b00;
            asel_s0 <= 3'b000;
            asel_s1 <= 3'b000;
        end else if (ce) begin
            scl_s <= {scl_s[1:0], bus.scl};
            sda_s <= {sda_s[1:0], bus.sda};
            en_s <= {en_s[0], en_pin};
            asel_s0 <= addr_sel;
            asel_s1 <= asel_s0;
        end
    end
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_ev = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_ev = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    assign commit = scl_fall & (st_q == S_DATA) & (cnt_q == 4'd8);
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            otp_mem[0][i] = DEF_PAGE[8*i +: 8];
            otp_mem[1][i] = otp_page1[8*i +: 8];
            otp_mem[2][i] = otp_page2[8*i +: 8];
        end
    end
    // loader sequence, restarted by every enable
    always_ff @(posedge mclk) begin
        if (reset) begin
            ld_q <= L_OFF;
            idx_q <= '0;
            ready_q <= 1'b0;
            dev_addr_q <= icfg_pkg::ADDR_BASE;
        end else if (ce) begin
            if (!en_s[1]) begin
                ld_q <= L_OFF;
                idx_q <= '0;
                ready_q <= 1'b0;
            end else begin
                case (ld_q)
                    L_OFF: begin
                        dev_addr_q <= icfg_pkg::ADDR_BASE + {4'h0, asel_s1};
                        idx_q <= '0;
                        ld_q <= L_DEF;
                    end
                    L_DEF: begin
                        idx_q <= IW'(idx_q + 1'b1);
                        if (idx_q == IW'(NREG - 1)) begin
                            idx_q <= '0;
                            ld_q <= (|otp_prog) ? L_NEW : L_RDY;
                        end
                    end
                    L_NEW: begin
                        idx_q <= IW'(idx_q + 1'b1);
                        if (idx_q == IW'(NREG - 1)) begin
                            ld_q <= L_RDY;
                        end
                    end
                    L_RDY: begin
                        ready_q <= 1'b1;
                    end
                    default: begin
                        ld_q <= L_OFF;
                    end
                endcase
            end
        end
    end
    // configuration registers: otp load or bus write
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_q <= '0;
        end else if (ce) begin
            if (ld_q == L_DEF) begin
                cfg_q[8*idx_q +: 8] <= otp_mem[0][idx_q];
            end else if (ld_q == L_NEW) begin
                cfg_q[8*idx_q +: 8] <= otp_prog[1] ? otp_mem[2][idx_q] : otp_mem[1][idx_q];
            end else if (commit && int'(ptr_q) < NREG) begin
                cfg_q[8*int'(ptr_q) +: 8] <= shift_q;
            end
        end
    end
    // bus slave state machine, held idle until loaded
    always_ff @(posedge mclk) begin
        if (reset || (ce && !ready_q)) begin
            st_q <= S_IDLE;
            cnt_q <= 4'd0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            sda_oe_q <= 1'b0;
        end else if (ce) begin
            if (start_ev) begin
                st_q <= S_ADDR;
                cnt_q <= 4'd0;
                sda_oe_q <= 1'b0;
            end else if (stop_ev) begin
                st_q <= S_IDLE;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (st_q == S_ADDR || st_q == S_REG || st_q == S_DATA) begin
                    shift_q <= {shift_q[6:0], sda_s[1]};
                    cnt_q <= cnt_q + 4'd1;
                end
            end else if (scl_fall) begin
                case (st_q)
                    S_ADDR: begin
                        if (cnt_q == 4'd8) begin
                            if (shift_q == {dev_addr_q, 1'b0}) begin
                                sda_oe_q <= 1'b1;
                                st_q <= S_ACKA;
                            end else begin
                                st_q <= S_SKIP;
                            end
                        end
                    end
                    S_REG, S_DATA: begin
                        if (cnt_q == 4'd8) begin
                            if (st_q == S_REG) ptr_q <= shift_q;
                            sda_oe_q <= 1'b1;
                            st_q <= (st_q == S_REG) ? S_ACKR : S_ACKD;
                        end
                    end
                    S_ACKA, S_ACKR, S_ACKD: begin
                        // release after the acknowledge clock
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'd0;
                        if (st_q == S_ACKD) ptr_q <= ptr_q + 8'd1;
                        st_q <= (st_q == S_ACKA) ? S_REG : S_DATA;
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign dhalf = 32'((dither_long_q ? DITHER_LONG_CYC : DITHER_SHORT_CYC) / 2);
    always_ff @(posedge mclk) begin
        if (reset) begin
            dither_wide_q <= 1'b0;
            dither_long_q <= 1'b0;
            dither_up_q <= 1'b0;
            dcnt_q <= 32'h0000_0000;
        end else if (ce) begin
            dither_wide_q <= cfg_q[8*icfg_pkg::DITHER_REG + icfg_pkg::DITHER_RANGE_BIT];
            dither_long_q <= cfg_q[8*icfg_pkg::DITHER_REG + icfg_pkg::DITHER_PERIOD_BIT];
            if (!ready_q || dcnt_q >= dhalf - 32'd1) begin
                dcnt_q <= 32'h0000_0000;
                dither_up_q <= ready_q & ~dither_up_q;
            end else begin
                dcnt_q <= dcnt_q + 32'd1;
            end
        end
    end
endmodule

// [core/icfg_host.sv]
// controller end: apb driven i2c master issuing single register writes
`timescale 1ns/1ps
module icfg_host #(
    parameter int QTR_CYC = icfg_pkg::SCL_QTR_CYC,
    parameter int FREE_CYC = icfg_pkg::BUS_FREE_CYC
) (
    // clock, reset, clock enable
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // two wire link
    icfg_if.host             bus
);
    if (QTR_CYC < 2 || FREE_CYC < 1) begin : g_chk
        $error("timing counts too small");
    end

    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_START = 5'h02,
        H_BYTE  = 5'h04,
        H_STOP  = 5'h08,
        H_FREE  = 5'h10
    } icfg_hst_t;

    icfg_hst_t   st_q;
    logic [15:0] qt_q;
    logic [1:0]  ph_q;
    logic [3:0]  bitn_q;
    logic [1:0]  k_q;
    logic [15:0] free_q;
    logic [6:0]  slave_q;
    logic [7:0]  rega_q;
    logic [7:0]  wdata_q;
    logic        busy_q;
    logic        nack_q;
    logic        done_q;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic [1:0]  sda_s;
    logic        tick;
    logic        acc;
    logic        go;
    logic        mapped;
    logic [7:0]  tx;

    // open drain outputs
    assign bus.scl_m_o = 1'b0;
    assign bus.sda_m_o = 1'b0;
    assign bus.scl_m_oe = scl_oe_q;
    assign bus.sda_m_oe = sda_oe_q;

    // apb access phase completes when pready is seen high
    assign acc = psel & penable & pready;
    assign go = acc & pwrite & (paddr == icfg_pkg::OFS_CTRL) & pwdata[icfg_pkg::CTRL_GO_BIT] & ~busy_q;
    assign mapped = (paddr == icfg_pkg::OFS_CTRL) | (paddr == icfg_pkg::OFS_SLAVE) |
                    (paddr == icfg_pkg::OFS_REGA) | (paddr == icfg_pkg::OFS_WDATA) |
                    (paddr == icfg_pkg::OFS_STAT);
    assign tick = (qt_q == 16'(QTR_CYC - 1));
    assign tx = (k_q == 2'd0) ? {slave_q, 1'b0} : (k_q == 2'd1) ? rega_q : wdata_q;

    // apb answer: one wait state, registered read data
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            case (paddr)
                icfg_pkg::OFS_SLAVE: prdata <= {25'h000_0000, slave_q};
                icfg_pkg::OFS_REGA:  prdata <= {24'h00_0000, rega_q};
                icfg_pkg::OFS_WDATA: prdata <= {24'h00_0000, wdata_q};
                icfg_pkg::OFS_STAT:  prdata <= {29'h0000_0000, done_q, nack_q, busy_q};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

    // transfer fields, frozen while a transfer runs
    always_ff @(posedge mclk) begin
        if (reset) begin
            slave_q <= icfg_pkg::ADDR_BASE;
            rega_q <= 8'h00;
            wdata_q <= 8'h00;
        end else if (ce && acc && pwrite && !busy_q) begin
            if (paddr == icfg_pkg::OFS_SLAVE) slave_q <= pwdata[6:0];
            if (paddr == icfg_pkg::OFS_REGA) rega_q <= pwdata[7:0];
            if (paddr == icfg_pkg::OFS_WDATA) wdata_q <= pwdata[7:0];
        end
    end

    // returning data line through two flip-flops
    always_ff @(posedge mclk) begin
        if (reset) begin
            sda_s <= 2'b11;
        end else if (ce) begin
            sda_s <= {sda_s[0], bus.sda};
        end
    end

    // quarter bit timer, scl made by division of mclk
    always_ff @(posedge mclk) begin
        if (reset || (ce && (st_q == H_IDLE || st_q == H_FREE))) begin
            qt_q <= 16'h0000;
            ph_q <= 2'd0;
        end else if (ce) begin
            qt_q <= tick ? 16'h0000 : qt_q + 16'd1;
            if (tick) ph_q <= ph_q + 2'd1;
        end
    end

    // bit level engine
    always_ff @(posedge mclk) begin
        if (reset) begin
            st_q <= H_IDLE;
            bitn_q <= 4'd0;
            k_q <= 2'd0;
            free_q <= 16'h0000;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            done_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (ce) begin
            case (st_q)
                H_IDLE: begin
                    if (go) begin
                        busy_q <= 1'b1;
                        nack_q <= 1'b0;
                        done_q <= 1'b0;
                        st_q <= H_START;
                    end
                end
                H_START: begin
                    if (tick) begin
                        case (ph_q)
                            2'd0: begin
                                scl_oe_q <= 1'b1;
                                sda_oe_q <= 1'b0;
                            end
                            2'd1: scl_oe_q <= 1'b0;
                            2'd2: sda_oe_q <= 1'b1;
                            default: begin
                                scl_oe_q <= 1'b1;
                                bitn_q <= 4'd0;
                                k_q <= 2'd0;
                                st_q <= H_BYTE;
                            end
                        endcase
                    end
                end
                H_BYTE: begin
                    if (tick) begin
                        case (ph_q)
                            2'd0: sda_oe_q <= (bitn_q < 4'd8) ? ~tx[3'd7 - bitn_q[2:0]] : 1'b0;
                            2'd1: scl_oe_q <= 1'b0;
                            2'd2: begin
                                if (bitn_q == 4'd8) nack_q <= sda_s[1];
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                bitn_q <= bitn_q + 4'd1;
                                if (bitn_q == 4'd8) begin
                                    bitn_q <= 4'd0;
                                    k_q <= k_q + 2'd1;
                                    if (nack_q || k_q == 2'd2) st_q <= H_STOP;
                                end
                            end
                        endcase
                    end
                end
                H_STOP: begin
                    if (tick) begin
                        case (ph_q)
                            2'd0: sda_oe_q <= 1'b1;
                            2'd1: scl_oe_q <= 1'b0;
                            2'd2: sda_oe_q <= 1'b0;
                            default: begin
                                free_q <= 16'h0000;
                                st_q <= H_FREE;
                            end
                        endcase
                    end
                end
                H_FREE: begin
                    free_q <= free_q + 16'd1;
                    if (free_q >= 16'(FREE_CYC - 1)) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        st_q <= H_IDLE;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule

// [verif/icfg_link_chk.sv]
// protocol checker for the two wire link between controller and device
`timescale 1ns/1ps
module icfg_link_chk #(
    parameter int FREE_CYC = 10
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe
);
    logic       scl_q;
    logic       sda_q;
    logic [5:0] bits_q;
    int         free_q;
    logic       start_w;
    logic       stop_w;
    // start and stop seen on the wires
    assign start_w = scl & scl_q & sda_q & ~sda;
    assign stop_w  = scl & scl_q & ~sda_q & sda;
    // previous wire levels
    always_ff @(posedge mclk) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    // clock rises since the last start
    always_ff @(posedge mclk) begin
        if (reset || start_w) bits_q <= 6'h00;
        else if (scl && !scl_q && bits_q != 6'h3f) bits_q <= bits_q + 6'h01;
    end
    // cycles since the last stop, saturating
    always_ff @(posedge mclk) begin
        if (reset) free_q <= 1000;
        else if (stop_w) free_q <= 0;
        else if (free_q < 1000) free_q <= free_q + 1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_ack_held; sda_s_oe [*8]; endsequence
    sequence s_next_ack; ##[100:200] $rose(sda_s_oe); endsequence
    AST_DEV_SDA_LOW_CLK: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("device moved data line while clock high");
    AST_START_CLK_FALL: assert property (start_w |-> ##[1:16] !scl)
        else $error("clock did not fall after start");
    AST_ACK_HELD: assert property ($rose(sda_s_oe) |-> s_ack_held)
        else $error("acknowledge not held");
    AST_SENDER_RELEASE: assert property (scl && sda_s_oe |-> !sda_m_oe)
        else $error("sender drives data during acknowledge");
    AST_BUS_FREE: assert property (start_w |-> free_q >= FREE_CYC)
        else $error("start too soon after stop");
    AST_ACK_AFTER_8: assert property ($rose(sda_s_oe) |-> bits_q == 6'h08 || bits_q == 6'h11 || bits_q == 6'h1a)
        else $error("acknowledge not after eight bits");
    AST_ACK_EACH_BYTE: assert property ($rose(sda_s_oe) && bits_q != 6'h1a |-> s_next_ack)
        else $error("later byte not acknowledged");
    AST_RELEASED_AT_FRAME: assert property (start_w || stop_w |-> !sda_s_oe)
        else $error("device holds data at start or stop");
endmodule

// [verif/i2c_config_slave_otp_loader_test.sv]
// self-checking bench for controller and configuration slave
`timescale 1ns/1ps
module i2c_config_slave_otp_loader_test;
    localparam logic [31:0] DEFP = 32'h0000_0002;
    localparam logic [31:0] PG1 = 32'h4433_2211;
    localparam logic [31:0] PG2 = 32'h8877_6655;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        en_pin = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [2:0]  addr_sel = 3'h0;
    logic [1:0]  otp_prog = 2'h0;
    logic        ce = 1'b1;
    logic        du, d0;
    logic [31:0] pg1 = PG1;
    logic [31:0] pg2 = PG2;
    logic [31:0] prdata, rd, cfg_q;
    logic        pready, pslverr, err, ready_q, dw, dl;
    int          error_cnt = 0, samples_checked = 0, cyc = 0;
    icfg_if link ();
    always #5 mclk = ~mclk;
    icfg_host #(.QTR_CYC(4), .FREE_CYC(10)) icfg_host_inst (.mclk(mclk), .reset(reset), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(link.host));
    icfg_dev #(.DEF_PAGE(DEFP), .DITHER_SHORT_CYC(20), .DITHER_LONG_CYC(30)) icfg_dev_inst (.mclk(mclk),
        .reset(reset), .ce(ce), .bus(link.dev), .en_pin(en_pin), .addr_sel(addr_sel), .otp_page1(pg1),
        .otp_page2(pg2), .otp_prog(otp_prog), .ready_q(ready_q), .cfg_q(cfg_q), .dither_wide_q(dw),
        .dither_long_q(dl), .dither_up_q(du));
    icfg_link_chk #(.FREE_CYC(10)) chk_inst (.mclk(mclk), .reset(reset), .scl(link.scl), .sda(link.sda),
        .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // single register write over the link, leaves status in rd
    task automatic xfer(input logic [7:0] sl, input logic [7:0] r, input logic [7:0] d);
        apb(1'b1, icfg_pkg::OFS_SLAVE, {24'h00_0000, sl});
        apb(1'b1, icfg_pkg::OFS_REGA, {24'h00_0000, r});
        apb(1'b1, icfg_pkg::OFS_WDATA, {24'h00_0000, d});
        apb(1'b1, icfg_pkg::OFS_CTRL, 32'h0000_0001);
        do apb(1'b0, icfg_pkg::OFS_STAT, 32'h0000_0000); while (rd[0] !== 1'b0);
    endtask
    // re-enable the device with a strap band and page indicator
    task automatic power(input logic [2:0] band, input logic [1:0] prog);
        en_pin <= 1'b0;
        addr_sel <= band;
        otp_prog <= prog;
        @(posedge mclk);
        while (ready_q !== 1'b0) @(posedge mclk);
        en_pin <= 1'b1;
        while (ready_q !== 1'b1) @(posedge mclk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        apb(1'b0, icfg_pkg::OFS_SLAVE, 32'h0000_0000);
        check(rd, 32'h0000_0021);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        xfer(8'h21, 8'h01, 8'h77);
        check(rd, 32'h0000_0006);
        $display("test registers and disabled device done");
        power(3'h0, 2'h0);
        check(cfg_q, DEFP);
        power(3'h0, 2'h1);
        check(cfg_q, PG1);
        power(3'h0, 2'h3);
        check(cfg_q, PG2);
        $display("test otp load done");
        for (int i = 0; i < 8; i++) begin
            power(i[2:0], 2'h0);
            xfer(8'h21 + i[7:0], 8'h01, 8'h5a ^ i[7:0]);
            check(rd, 32'h0000_0004);
            check(cfg_q, {DEFP[31:16], 8'h5a ^ i[7:0], DEFP[7:0]});
        end
        $display("test strap addresses done");
        xfer(8'h27, 8'h01, 8'h33);
        check(rd, 32'h0000_0006);
        check(cfg_q, {DEFP[31:16], 8'h5d, DEFP[7:0]});
        $display("test address mismatch done");
        for (int j = 0; j < 4; j++) begin
            xfer(8'h28, 8'h00, j[7:0]);
            check({30'h0000_0000, dl, dw}, j[31:0]);
        end
        // long period of 30 cycles: direction flips once in any 15 edges
        d0 = du;
        repeat (15) @(posedge mclk);
        check({31'h0000_0000, du}, {31'h0000_0000, ~d0});
        // clock enable low freezes the triangle
        ce <= 1'b0;
        @(posedge mclk);
        d0 = du;
        repeat (20) @(posedge mclk);
        check({31'h0000_0000, du}, {31'h0000_0000, d0});
        ce <= 1'b1;
        $display("test dither done");
        give_verdict();
    end
endmodule
